/* macc_fir.sv */
/*
  single-multiplier multiply-accumulate fir filter: control counters, cyclic data buffer and
  coefficient store in one dual-port memory, embedded-control variant, symmetric rounding
  cycle, capture register and apb register slave.
  assumes upstream sample logic and downstream result logic on pclk, and an apb master.
*/
// What this block does
// - separate counters address the coefficient half and the data buffer half
// - data counter stalls one cycle per output with a sample pending; new sample written then
// - memory addressed every clock; coefficient counter wraps after last index
// - stalled buffer location reads oldest sample before newest overwrites it
// - coefficient counter never disabled; newest sample meets first coefficient
// - inverted write enable drives the accumulator load control
// - load control delayed by shift register matching the four-clock mac latency
// - embedded variant stores next address, load, enable, write beside coefficient
// - stored address is the address needed two cycles later
// - fed-back address lsb forced low one cycle to kick-start the loop
// - coefficients in upper half; only address lsb masked, mask registered
// - embedded variant allowed only below 256 taps and above 9-bit data
// - full-precision result limited to the 48-bit accumulator
// - truncation keeps only the top output bits of the full result
// - symmetric rounding: positives round up, negatives round down
// - always add 0.0111 constant, plus carry-in when value is positive
// - extra rounding cycle adds the constant to the accumulator; product is ignored
// - rounding cycle keeps accumulator feedback: operation select 0101100
// - port a is the read-write data buffer, port b a read-only store
// - capture register holds each final result for downstream logic
// - loading the first product uses operation select 0100101
`include "macc_fir_cfg.svh"

module macc_fir #(
  parameter int TAPS = 16,
  parameter int DATA_W = 18,
  parameter int COEF_W = 18,
  parameter int OUT_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic [OUT_W-1:0] result_data,
  output logic result_valid,
  output logic [6:0] operation_select
);

  // ----------------------------------------
  // derived widths and constants
  // ----------------------------------------
  localparam int PROD_W = DATA_W + COEF_W;
  localparam int FULL_RAW = DATA_W + COEF_W - 1 + $clog2(TAPS);
  localparam int FULL_W = (FULL_RAW > `ACC_W) ? `ACC_W : FULL_RAW;
  localparam int FRAC_W = FULL_W - OUT_W;
  localparam logic [`ACC_W-1:0] ROUND_CONST = (FRAC_W > 0) ?
    ((`ACC_W'(1) << (FRAC_W - 1)) - `ACC_W'(1)) : '0;
  localparam bit EMBED_OK = (TAPS < `EMBED_MAX_TAPS) && (DATA_W > `EMBED_MIN_DATA_W);

  typedef struct packed {
    macc_fir_pkg::run_state_t state;
    logic [`CTRL_W-1:0] ctrl;
    logic [`IDX_W-1:0] coef_idx;
    logic [`MEM_DEPTH-1:0][`WORD_W-1:0] mem;
    logic [`IDX_W-1:0] dcnt;
    logic [`SLOT_W-1:0] slot;
    logic we_q;
    logic pend;
    logic [DATA_W-1:0] hold;
    logic [`WORD_W-1:0] lat_a;
    logic [`WORD_W-1:0] out_a;
    logic [`WORD_W-1:0] lat_b;
    logic [`WORD_W-1:0] out_b;
    logic mask;
    logic [DATA_W-1:0] opa;
    logic [COEF_W-1:0] opb;
    logic [`ACC_W-1:0] prod;
    logic [`LOAD_DELAY-1:0][1:0] sr;
    logic [6:0] opsel;
    logic [`ACC_W-1:0] acc;
    logic [OUT_W-1:0] cap;
    logic rvalid;
    logic prdy;
    logic [31:0] prdata;
  } state_t;

  state_t s;
  state_t n;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic macc_fir_pkg::reg_sel_t reg_decode(input logic [11:0] a);
    case (a)
      `REG_CTRL: return macc_fir_pkg::SEL_CTRL;
      `REG_STATUS: return macc_fir_pkg::SEL_STATUS;
      `REG_COEF_ADDR: return macc_fir_pkg::SEL_COEF_ADDR;
      `REG_COEF_DATA: return macc_fir_pkg::SEL_COEF_DATA;
      `REG_RESULT: return macc_fir_pkg::SEL_RESULT;
      default: return macc_fir_pkg::SEL_NONE;
    endcase
  endfunction

  function automatic logic [6:0] opsel_of(input macc_fir_pkg::stage_ctrl_t c);
    if (c.round) begin
      return `OPSEL_ROUND;
    end else if (!c.load_n) begin
      return `OPSEL_LOAD;
    end
    return `OPSEL_ACC;
  endfunction

  // ----------------------------------------
  // combinational signals
  // ----------------------------------------
  macc_fir_pkg::reg_sel_t sel;
  logic running;
  logic embed;
  logic access;
  logic we_slot;
  logic we_eff;
  logic ce;
  logic [`ADDR_W-1:0] addr_a;
  logic [`ADDR_W-1:0] addr_b;
  logic signed [PROD_W-1:0] prod_full;
  logic [`ACC_W-1:0] rsum;
  logic cin;
  macc_fir_pkg::stage_ctrl_t emb_ctrl;
  logic [31:0] rd_word;

  assign sel = reg_decode(paddr);
  assign running = (s.state == macc_fir_pkg::ST_RUN);
  assign embed = s.ctrl[`CTRL_EMBED] & EMBED_OK;
  assign access = psel & penable & pready;
  assign pready = penable & s.prdy & clk_en;
  assign pslverr = psel & penable & ((sel == macc_fir_pkg::SEL_NONE) |
                   ((sel == macc_fir_pkg::SEL_COEF_DATA) & pwrite & running));
  assign prdata = s.prdata;
  assign sample_ready = ~s.pend;
  assign result_data = s.cap;
  assign result_valid = s.rvalid;
  assign operation_select = s.opsel;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    n = s;
    n.rvalid = 1'b0;
    rd_word = '0;
    we_slot = 1'b0;
    we_eff = 1'b0;
    ce = 1'b0;
    addr_a = {1'b0, s.dcnt};
    addr_b = '0;
    emb_ctrl = '0;
    prod_full = $signed(s.opa) * $signed(s.opb);
    cin = s.ctrl[`CTRL_ROUND] & ~s.acc[`ACC_W-1];
    rsum = s.acc + (s.ctrl[`CTRL_ROUND] ? ROUND_CONST : '0) + `ACC_W'(cin);

    // apb: read data staged in the setup cycle, write at the access edge
    case (sel)
      macc_fir_pkg::SEL_CTRL: rd_word = 32'(s.ctrl);
      macc_fir_pkg::SEL_STATUS: rd_word = {15'h0000, s.slot, 5'h00, embed, s.pend, running};
      macc_fir_pkg::SEL_COEF_ADDR: rd_word = 32'(s.coef_idx);
      macc_fir_pkg::SEL_RESULT: rd_word = 32'(s.cap);
      default: rd_word = '0;
    endcase
    if (psel & ~s.prdy) begin
      n.prdata = rd_word;
      n.prdy = 1'b1;
    end else if (access) begin
      n.prdy = 1'b0;
    end
    if (access & pwrite & ~pslverr) begin
      case (sel)
        macc_fir_pkg::SEL_CTRL: n.ctrl = pwdata[`CTRL_W-1:0];
        macc_fir_pkg::SEL_COEF_ADDR: n.coef_idx = pwdata[`IDX_W-1:0];
        macc_fir_pkg::SEL_COEF_DATA: begin
          n.mem[{1'b1, s.coef_idx}] = `WORD_W'(pwdata);
          n.coef_idx = s.coef_idx + `IDX_W'(1);
        end
        default: ;
      endcase
    end

    // upstream sample holding register
    if (sample_valid & ~s.pend) begin
      n.hold = sample_data;
      n.pend = 1'b1;
    end

    case (s.state)
      macc_fir_pkg::ST_IDLE: begin
        n.mask = 1'b1;
        n.lat_b = `KICK_WORD;
        n.out_b = `KICK_WORD;
        n.slot = '0;
        n.dcnt = '0;
        // first slot after start loads; pipeline idles as plain accumulate
        n.we_q = 1'b1;
        for (int k = 0; k < `LOAD_DELAY; k++) begin
          n.sr[k] = macc_fir_pkg::stage_ctrl_t'{round: 1'b0, load_n: 1'b1};
        end
        if (s.ctrl[`CTRL_RUN]) begin
          n.state = macc_fir_pkg::ST_RUN;
        end
      end
      macc_fir_pkg::ST_RUN: begin
        if (!s.ctrl[`CTRL_RUN]) begin
          n.state = macc_fir_pkg::ST_IDLE;
        end
        n.mask = 1'b0;
        we_slot = (s.slot == `SLOT_W'(TAPS));
        if (embed) begin
          ce = s.out_b[`F_CE];
          we_eff = s.out_b[`F_WE] & s.pend;
          addr_b = {1'b1, s.out_b[`F_NADDR_MSB:`F_NADDR_LSB+1],
                    s.out_b[`F_NADDR_LSB] & ~s.mask};
          emb_ctrl.round = s.out_b[`F_ROUND];
          emb_ctrl.load_n = s.out_b[`F_LOADN];
        end else begin
          we_eff = we_slot & s.pend;
          ce = ~we_eff;
          addr_b = {1'b1, s.slot[`IDX_W-1:0]};
        end

        // port a: old word read, then newest sample overwrites it
        n.lat_a = s.mem[addr_a];
        if (we_eff) begin
          n.mem[addr_a] = `WORD_W'(s.hold);
          n.pend = 1'b0;
        end
        n.out_a = s.lat_a;
        if (ce) begin
          // ring of taps+1 words: the stalled word is the oldest, replaced by the newest
          n.dcnt = (s.dcnt == '0) ? `IDX_W'(TAPS) : s.dcnt - `IDX_W'(1);
        end

        // port b: read-only coefficient store, latch then output register
        n.lat_b = s.mem[addr_b];
        n.out_b = s.lat_b;
        n.slot = we_slot ? '0 : s.slot + `SLOT_W'(1);
        n.we_q = we_slot;

        // control pipeline matched to memory and multiplier latency
        n.sr[0] = {we_slot, ~s.we_q};
        for (int k = 1; k < `LOAD_DELAY; k++) begin
          n.sr[k] = s.sr[k-1];
        end
        if (embed) begin
          n.sr[2] = emb_ctrl;
        end
      end
      default: n.state = macc_fir_pkg::ST_IDLE;
    endcase

    // operand, product and accumulator stages
    n.opa = s.out_a[DATA_W-1:0];
    n.opb = s.out_b[COEF_W-1:0];
    n.prod = `ACC_W'(prod_full);
    n.opsel = running ? opsel_of(s.sr[`LOAD_DELAY-2]) : '0;
    if (running) begin
      case (s.opsel)
        `OPSEL_LOAD: n.acc = s.prod;
        `OPSEL_ACC: n.acc = s.acc + s.prod;
        `OPSEL_ROUND: begin
          n.acc = rsum;
          n.cap = rsum[FULL_W-1 -: OUT_W];
          n.rvalid = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= n;
    end
  end

endmodule

/* macc_fir_cfg.svh */
/*
  offsets, field positions, codes and timing counts of the multiply-accumulate fir block.
  assumes inclusion by bare name from the design file.
*/
`ifndef MACC_FIR_CFG_SVH
`define MACC_FIR_CFG_SVH

// ----------------------------------------
// register offsets (apb byte addresses)
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COEF_ADDR 12'h008
`define REG_COEF_DATA 12'h00C
`define REG_RESULT 12'h010

// ----------------------------------------
// control register bits
// ----------------------------------------
`define CTRL_RUN 0
`define CTRL_EMBED 1
`define CTRL_ROUND 2
`define CTRL_W 3

// ----------------------------------------
// memory organisation and word fields
// ----------------------------------------
`define WORD_W 36
`define MEM_DEPTH 512
`define IDX_W 8
`define ADDR_W 9
`define F_NADDR_LSB 18
`define F_NADDR_MSB 25
`define F_LOADN 26
`define F_ROUND 27
`define F_CE 28
`define F_WE 29
`define KICK_WORD 36'h000040000

// ----------------------------------------
// slice, pipeline and limits
// ----------------------------------------
`define ACC_W 48
`define LOAD_DELAY 4
`define OPSEL_LOAD 7'h25
`define OPSEL_ACC 7'h35
`define OPSEL_ROUND 7'h2C
`define EMBED_MAX_TAPS 256
`define EMBED_MIN_DATA_W 9
`define SLOT_W 9

`endif

/* macc_fir_pkg.sv */
/*
  types shared by the multiply-accumulate fir block.
  assumes nothing of its surroundings.
*/
package macc_fir_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } run_state_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_STATUS,
    SEL_COEF_ADDR,
    SEL_COEF_DATA,
    SEL_RESULT
  } reg_sel_t;

  typedef struct packed {
    logic round;
    logic load_n;
  } stage_ctrl_t;

endpackage

/* macc_fir_chk.sv */
/*
  port checker for the multiply-accumulate fir block.
  assumes a bind onto macc_fir with matching parameters.
*/
module macc_fir_chk #(
  parameter int TAPS = 16,
  parameter int OUT_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [OUT_W-1:0] result_data,
  input wire logic result_valid,
  input wire logic [6:0] operation_select
);
  localparam int TP = TAPS;
  // ----------------
  // port relations
  // ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_opsel_codes: assert property (
    operation_select inside {7'h00, 7'h25, 7'h35, 7'h2C}) else $error("illegal operation code");
  a_load_to_round: assert property (disable iff (!presetn || !clk_en)
    operation_select == 7'h25 |-> ##TP operation_select == 7'h2C) else $error("round code late");
  a_load_then_acc: assert property (
    operation_select == 7'h25 && clk_en |=> operation_select == 7'h35) else $error("no accumulate after load");
  a_round_result: assert property (
    operation_select == 7'h2C && clk_en |=> result_valid) else $error("no result after round");
  a_valid_pulse: assert property (
    result_valid && clk_en |=> !result_valid) else $error("result valid too long");
  a_result_hold: assert property (
    !$stable(result_data) |-> result_valid) else $error("result changed without valid");
  a_take_ready: assert property (
    sample_valid && sample_ready && clk_en |=> !sample_ready) else $error("ready held after take");
  a_ready_round: assert property (disable iff (!presetn || !clk_en)
    $rose(sample_ready) |-> ##3 operation_select == 7'h2C) else $error("round not aligned to write");
  a_unmapped_err:
    assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("unmapped without error");
  a_freeze_hold:
    assert property (!clk_en |-> !pready ##1 $stable(operation_select)) else $error("moved while frozen");
endmodule

/* fir_stream_partner.sv */
/*
  upstream sample source and downstream result counter for the fir block.
  assumes one clock shared with the block and a testbench requesting samples.
*/
module fir_stream_partner #(
  parameter int DATA_W = 18,
  parameter int GAP = 17
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic [DATA_W-1:0] value,
  input wire logic sample_ready,
  input wire logic result_valid,
  output logic sample_valid,
  output logic [DATA_W-1:0] sample_data,
  output logic busy,
  output int n_results
);
  int gap_q;
  assign busy = sample_valid || gap_q != 0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      sample_data <= '0;
      gap_q <= 0;
      n_results <= 0;
    end else begin
      if (result_valid)
        n_results <= n_results + 1;
      if (!sample_valid || sample_ready)
        sample_data <= ~sample_data;
      if (sample_valid && sample_ready) begin
        sample_valid <= 1'b0;
        gap_q <= GAP;
      end else if (!sample_valid && send && gap_q == 0) begin
        sample_valid <= 1'b1;
        sample_data <= value;
      end else if (gap_q != 0)
        gap_q <= gap_q - 1;
    end
  end
endmodule

/* test_macc_fir.sv */
/*
  self-checking testbench for the multiply-accumulate fir block, four taps.
  assumes the block, its checker and the stream partner compiled before it.
*/
module test_macc_fir;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [17:0] smp;
    logic rnd;
    logic [17:0] exp;
  } row_t;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, send = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [17:0] value = 18'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, sample_ready, sample_valid, result_valid, busy, e;
  logic [17:0] sample_data, result_data;
  logic [6:0] operation_select;
  int n_fail = 0;
  int checks = 0;
  int n_results, n;
  logic [31:0] coef [4] = '{32'h00010000, 32'h00008000, 32'h00000000, 32'h00030000};
  row_t rows [9] = '{'{18'h00014, 1'b1, 18'h00003}, '{18'h3FFD7, 1'b1, 18'h3FFFC},
    '{18'h00007, 1'b1, 18'h3FFFE}, '{18'h3FFFB, 1'b1, 18'h3FFFD}, '{18'h3FFEC, 1'b1, 18'h00002},
    '{18'h3FFF8, 1'b0, 18'h3FFFC}, '{18'h0000C, 1'b0, 18'h00001}, '{18'h3FFF4, 1'b1, 18'h00002},
    '{18'h3FFEA, 1'b1, 18'h3FFFD}};
  always #5 pclk = ~pclk;
  macc_fir #(.TAPS(4)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .result_data(result_data), .result_valid(result_valid),
    .operation_select(operation_select));
  fir_stream_partner #(.GAP(5)) i_src (.pclk(pclk), .presetn(presetn), .send(send), .value(value),
    .sample_ready(sample_ready), .result_valid(result_valid), .sample_valid(sample_valid),
    .sample_data(sample_data), .busy(busy), .n_results(n_results));
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic push(input logic [17:0] x);
    while (busy !== 1'b0) @(posedge pclk);
    send <= 1'b1;
    value <= x;
    @(posedge pclk);
    send <= 1'b0;
    do @(posedge pclk); while (sample_valid !== 1'b0 || sample_ready !== 1'b1);
    n = n_results;
    while (n_results < n + 2) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("sample_ready", 32'h1, {31'h0, sample_ready});
    chk("operation_select", 32'h0, {25'h0, operation_select});
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, q);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("reset and map test done");
    apb(1'b1, 12'h008, 32'h0);
    foreach (coef[i]) apb(1'b1, 12'h00C, coef[i]);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk("status embedded", 32'h4, q & 32'h4);
    $display("embedded flag test done");
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b1, 12'h00C, 32'h1);
    chk("coef write running", 32'h1, {31'h0, e});
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {29'h0, rows[i].rnd, 2'b01});
      push(rows[i].smp);
      chk("result_data", {14'h0, rows[i].exp}, {14'h0, result_data});
      apb(1'b0, 12'h010, 32'h0);
      chk("result register", {14'h0, rows[i].exp}, q);
      $display("row %0d done", i);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("status running", 32'h1, q & 32'h1);
    clk_en <= 1'b0;
    @(posedge pclk);
    q = {25'h0, operation_select};
    repeat (2) @(posedge pclk);
    chk("frozen operation_select", q, {25'h0, operation_select});
    clk_en <= 1'b1;
    $display("freeze test done");
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset ready", 32'h1, {31'h0, sample_ready});
    chk("reset valid", 32'h0, {31'h0, result_valid});
    chk("reset result", 32'h0, {14'h0, result_data});
    $display("mid-run reset test done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen hang");
    end_of_test();
  end
endmodule
bind macc_fir macc_fir_chk #(.TAPS(TAPS), .OUT_W(OUT_W)) i_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .result_data(result_data),
  .result_valid(result_valid), .operation_select(operation_select));
